// *** iblp_pkg.sv ***
// Shared constants and types of the interprocessor byte link port.
package iblp_pkg;

  // ===========================================================================
  // Widths and depths
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned CTL_W      = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned CNT_W      = 4;

  // ===========================================================================
  // Control line positions on the link
  localparam int unsigned CTL_TOK_REQ  = 0;  // Non-owner asks for the lines.
  localparam int unsigned CTL_TOK_GIVE = 1;  // Owner hands the lines over.
  localparam int unsigned CTL_STB      = 2;  // Sender marks a byte valid.
  localparam int unsigned CTL_ACK      = 3;  // Receiver takes the byte.

  // ===========================================================================
  // Byte position of the last byte of a word, reset values and the full count
  localparam logic [1:0]       LAST_BYTE_IDX = 2'h3;
  localparam logic [1:0]       BYTE_IDX_RST  = 2'h0;
  localparam logic [CNT_W-1:0] FIFO_CNT_RST  = 4'h0;
  localparam logic [CNT_W-1:0] FIFO_CNT_FULL = 4'h8;

  // ===========================================================================
  // Link figures: a byte may take at most this many clocks
  localparam int unsigned LINK_MBYTE_PER_S = 24;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned CLK_PER_BYTE_MAX = CLK_MHZ / LINK_MBYTE_PER_S;

  // ===========================================================================
  // Types
  typedef struct packed {
    logic [CTL_W-1:0]  ctl;
    logic [BYTE_W-1:0] data;
  } iblp_link_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_TX_WAIT_ACK,
    PH_TX_WAIT_REL,
    PH_RX_ACKED
  } iblp_phase_t;

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem;
    logic [CNT_W-1:0]                  cnt;
    logic                              full;
    logic                              empty;
  } iblp_fifo_st_t;

  typedef struct packed {
    iblp_phase_t       phase;
    logic              own;
    logic              sent;
    logic [1:0]        byte_idx;
    logic [WORD_W-1:0] tx_shift;
    logic [WORD_W-1:0] rx_word;
    iblp_link_t        pin_out;
    iblp_link_t        pin_oe;
  } iblp_port_st_t;

endpackage

// *** iblp_fifo.sv ***
// Eight-word shift FIFO whose head always sits in entry zero.
`timescale 1ns/1ps
`default_nettype none

module iblp_fifo
(
  input  wire logic                      clk_in,
  input  wire logic                      rst_b_in,
  input  wire logic                      push_in,
  input  wire logic [iblp_pkg::WORD_W-1:0] data_in,
  input  wire logic                      pop_in,
  output logic      [iblp_pkg::WORD_W-1:0] head_out,
  output logic                           full_out,
  output logic                           empty_out
);

  // ===========================================================================
  // State
  iblp_pkg::iblp_fifo_st_t st_reg;
  iblp_pkg::iblp_fifo_st_t st_next;
  logic [iblp_pkg::FIFO_DEPTH-1:0][iblp_pkg::WORD_W-1:0] entry_next;
  logic do_push;
  logic do_pop;

  // A push into a full buffer or a pop from an empty one is dropped here.
  assign do_push = push_in && !st_reg.full;
  assign do_pop  = pop_in && !st_reg.empty;

  // ===========================================================================
  // Per-entry next value: shifting on pop keeps the head in a flip-flop.
  for (genvar i = 0; i < iblp_pkg::FIFO_DEPTH; i++)
  begin : g_entry
    localparam int unsigned                IDX_I = i;
    localparam logic [iblp_pkg::CNT_W-1:0] IDX   = IDX_I[iblp_pkg::CNT_W-1:0];
    if (i == iblp_pkg::FIFO_DEPTH - 1)
    begin : g_top
      assign entry_next[i] =
        do_pop  ? ((do_push && st_reg.cnt == IDX + 4'h1) ? data_in : '0) :
        (do_push && st_reg.cnt == IDX) ? data_in : st_reg.mem[i];
    end
    else
    begin : g_mid
      assign entry_next[i] =
        do_pop  ? ((do_push && st_reg.cnt == IDX + 4'h1) ? data_in
                                                   : st_reg.mem[i+1]) :
        (do_push && st_reg.cnt == IDX) ? data_in : st_reg.mem[i];
    end
  end

  // Count and flags follow push and pop together.
  always_comb
  begin
    st_next     = st_reg;
    st_next.mem = entry_next;
    if (do_push && !do_pop)
      st_next.cnt = st_reg.cnt + 4'h1;
    else if (do_pop && !do_push)
      st_next.cnt = st_reg.cnt - 4'h1;
    st_next.full  = (st_next.cnt == iblp_pkg::FIFO_CNT_FULL);
    st_next.empty = (st_next.cnt == iblp_pkg::FIFO_CNT_RST);
  end

  // Register the whole state.
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      st_reg       <= '0;
      st_reg.empty <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign head_out  = st_reg.mem[0];
  assign full_out  = st_reg.full;
  assign empty_out = st_reg.empty;

endmodule

`default_nettype wire

// *** iblp_port.sv ***
// Interprocessor byte link port: word FIFOs and the byte-wide link engine.
//
// Operation
// - Eight data, four control lines, glueless.
// - Control lines arbitrate direction and timing.
// - Local side only writes and reads words.
// - Sender requests, receiver acknowledges before moving.
// - Each word crosses as four bytes.
// - Receiver reassembles bytes into input buffer.
// - Eight-word input and output buffers.
// - Same data lines both ways, auto direction.
// - Link supports up to 24 Mbytes/s.
`timescale 1ns/1ps
`default_nettype none

module iblp_port
#(
  parameter bit OWNER_AT_RESET = 1'b1
)
(
  input  wire logic                        CLK_SYS_IN,
  input  wire logic                        RST_B_IN,
  input  wire logic                        WR_VALID_IN,
  input  wire logic [iblp_pkg::WORD_W-1:0] WR_DATA_IN,
  output logic                             WR_READY_OUT,
  input  wire logic                        RD_READY_IN,
  output logic                             RD_VALID_OUT,
  output logic      [iblp_pkg::WORD_W-1:0] RD_DATA_OUT,
  input  wire iblp_pkg::iblp_link_t        LINK_IN,
  output iblp_pkg::iblp_link_t             LINK_OUT,
  output iblp_pkg::iblp_link_t             LINK_OE_OUT,
  output logic                             OWNER_OUT
);

  // ===========================================================================
  // Reset image: the owner drives data, strobe and hand-over lines.
  localparam iblp_pkg::iblp_port_st_t RST_ST = '{
    phase:    iblp_pkg::PH_IDLE,
    own:      OWNER_AT_RESET,
    sent:     1'b0,
    byte_idx: iblp_pkg::BYTE_IDX_RST,
    tx_shift: '0,
    rx_word:  '0,
    pin_out:  '0,
    pin_oe:   '{ctl:  (OWNER_AT_RESET ? 4'h6 : 4'h9),
                data: (OWNER_AT_RESET ? 8'hFF : 8'h00)}
  };

  // ===========================================================================
  // Declarations
  iblp_pkg::iblp_port_st_t st_reg;
  iblp_pkg::iblp_port_st_t st_next;
  logic                        tx_pop;
  logic                        tx_full;
  logic                        tx_empty;
  logic [iblp_pkg::WORD_W-1:0] tx_head;
  logic                        rx_push;
  logic [iblp_pkg::WORD_W-1:0] rx_assembled;
  logic                        rx_full;
  logic                        rx_empty;
  logic                        wr_ready_reg;
  logic                        rd_valid_reg;

  // ===========================================================================
  // Local buffers
  // output buffer
  iblp_fifo u_tx_fifo
  (
    .clk_in    (CLK_SYS_IN),
    .rst_b_in  (RST_B_IN),
    .push_in   (WR_VALID_IN && wr_ready_reg),
    .data_in   (WR_DATA_IN),
    .pop_in    (tx_pop),
    .head_out  (tx_head),
    .full_out  (tx_full),
    .empty_out (tx_empty)
  );

  iblp_fifo u_rx_fifo
  (
    .clk_in    (CLK_SYS_IN),
    .rst_b_in  (RST_B_IN),
    .push_in   (rx_push),
    .data_in   (rx_assembled),
    .pop_in    (RD_READY_IN && rd_valid_reg),
    .head_out  (RD_DATA_OUT),
    .full_out  (rx_full),
    .empty_out (rx_empty)
  );

  // Full and empty are flip-flops inside the buffers, so the ready and
  // valid outputs stay straight register outputs.
  // local stalls
  assign wr_ready_reg = !tx_full;
  assign rd_valid_reg = !rx_empty;

  // Byte that arrives lands in the top lane; after four bytes the first
  // one has walked down to bits 7:0.
  // first byte lowest
  assign rx_assembled = {LINK_IN.data, st_reg.rx_word[31:8]};

  // ===========================================================================
  // Link engine: ownership, byte handshake and pin enables.
  always_comb
  begin
    st_next = st_reg;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    // The hand-over line is a one-clock pulse.
    st_next.pin_out.ctl[iblp_pkg::CTL_TOK_GIVE] = 1'b0;
    case (st_reg.phase)
      iblp_pkg::PH_IDLE:
      begin
        if (st_reg.own)
        begin
          // A waiting peer wins once a word has gone or nothing is queued,
          // which keeps either side from starving the other.
          // token hand-over
          if (LINK_IN.ctl[iblp_pkg::CTL_TOK_REQ] && (st_reg.sent || tx_empty))
          begin
            st_next.own  = 1'b0;
            st_next.sent = 1'b0;
            st_next.pin_out.ctl[iblp_pkg::CTL_TOK_GIVE] = 1'b1;
          end
          else if (!tx_empty)
          begin
            tx_pop                                 = 1'b1;
            st_next.pin_out.data                   = tx_head[7:0];
            st_next.tx_shift                       = tx_head >> 8;
            st_next.byte_idx                       = iblp_pkg::BYTE_IDX_RST;
            st_next.pin_out.ctl[iblp_pkg::CTL_STB] = 1'b1;
            st_next.phase                          = iblp_pkg::PH_TX_WAIT_ACK;
          end
        end
        else
        begin
          // Our own hand-over pulse is still on the wire for one clock and
          // must not hand the lines straight back to us.
          // direction turns
          if (LINK_IN.ctl[iblp_pkg::CTL_TOK_GIVE] &&
              !st_reg.pin_out.ctl[iblp_pkg::CTL_TOK_GIVE])
          begin
            st_next.own  = 1'b1;
            st_next.sent = 1'b0;
          end
          // The first byte doubles as the word request, so a full input
          // buffer simply withholds the acknowledge until room appears.
          // withhold acknowledge
          else if (LINK_IN.ctl[iblp_pkg::CTL_STB] &&
                   (st_reg.byte_idx != iblp_pkg::BYTE_IDX_RST || !rx_full))
          begin
            st_next.rx_word                        = rx_assembled;
            st_next.byte_idx                       = st_reg.byte_idx + 2'h1;
            st_next.pin_out.ctl[iblp_pkg::CTL_ACK] = 1'b1;
            st_next.phase                          = iblp_pkg::PH_RX_ACKED;
            rx_push = (st_reg.byte_idx == iblp_pkg::LAST_BYTE_IDX);
          end
        end
      end
      iblp_pkg::PH_RX_ACKED:
      begin
        // Acknowledge drops once the sender has let the strobe go.
        if (!LINK_IN.ctl[iblp_pkg::CTL_STB])
        begin
          st_next.pin_out.ctl[iblp_pkg::CTL_ACK] = 1'b0;
          st_next.phase                          = iblp_pkg::PH_IDLE;
        end
      end
      iblp_pkg::PH_TX_WAIT_ACK:
      begin
        if (LINK_IN.ctl[iblp_pkg::CTL_ACK])
        begin
          st_next.pin_out.ctl[iblp_pkg::CTL_STB] = 1'b0;
          st_next.phase                          = iblp_pkg::PH_TX_WAIT_REL;
        end
      end
      iblp_pkg::PH_TX_WAIT_REL:
      begin
        // Full four-phase per byte costs about four clocks, near 50
        // Mbytes/s at this clock, which leaves margin on the link rate.
        // byte rate
        if (!LINK_IN.ctl[iblp_pkg::CTL_ACK])
        begin
          if (st_reg.byte_idx == iblp_pkg::LAST_BYTE_IDX)
          begin
            st_next.byte_idx = iblp_pkg::BYTE_IDX_RST;
            st_next.sent     = 1'b1;
            st_next.phase    = iblp_pkg::PH_IDLE;
          end
          else
          begin
            st_next.pin_out.data                   = st_reg.tx_shift[7:0];
            st_next.tx_shift                       = st_reg.tx_shift >> 8;
            st_next.byte_idx                       = st_reg.byte_idx + 2'h1;
            st_next.pin_out.ctl[iblp_pkg::CTL_STB] = 1'b1;
            st_next.phase                          = iblp_pkg::PH_TX_WAIT_ACK;
          end
        end
      end
      default:
      begin
        st_next.phase = iblp_pkg::PH_IDLE;
      end
    endcase

    // A port without the lines asks for them while it has words queued.
    // token request
    st_next.pin_out.ctl[iblp_pkg::CTL_TOK_REQ] = !st_next.own && !tx_empty;

    // Enables follow the next owner. The giver keeps its request and
    // acknowledge lines released during its hand-over pulse, because the
    // taker still drives them for that one clock.
    // twelve pins
    st_next.pin_oe.data = {iblp_pkg::BYTE_W{st_next.own}};
    st_next.pin_oe.ctl[iblp_pkg::CTL_STB]      = st_next.own;
    st_next.pin_oe.ctl[iblp_pkg::CTL_TOK_GIVE] =
      st_next.own || st_next.pin_out.ctl[iblp_pkg::CTL_TOK_GIVE];
    st_next.pin_oe.ctl[iblp_pkg::CTL_TOK_REQ] =
      !st_next.own && !st_next.pin_out.ctl[iblp_pkg::CTL_TOK_GIVE];
    st_next.pin_oe.ctl[iblp_pkg::CTL_ACK] =
      !st_next.own && !st_next.pin_out.ctl[iblp_pkg::CTL_TOK_GIVE];
  end

  // ===========================================================================
  // State register
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_B_IN)
      st_reg <= RST_ST;
    else
      st_reg <= st_next;
  end

  // ===========================================================================
  // Outputs, all taken from flip-flops
  assign WR_READY_OUT = wr_ready_reg;
  assign RD_VALID_OUT = rd_valid_reg;
  assign LINK_OUT     = st_reg.pin_out;
  assign LINK_OE_OUT  = st_reg.pin_oe;
  assign OWNER_OUT    = st_reg.own;

endmodule

`default_nettype wire

// *** iblp_port_asserts.sv ***
// Checker of the link port handshake and buffer flags.
`timescale 1ns/1ps
`default_nettype none

module iblp_port_asserts
(
  input wire logic                        CLK_SYS_IN,
  input wire logic                        RST_B_IN,
  input wire logic                        RD_READY_IN,
  input wire logic                        RD_VALID_OUT,
  input wire logic [iblp_pkg::WORD_W-1:0] RD_DATA_OUT,
  input wire logic                        WR_READY_OUT,
  input wire iblp_pkg::iblp_link_t        LINK_IN,
  input wire iblp_pkg::iblp_link_t        LINK_OUT,
  input wire iblp_pkg::iblp_link_t        LINK_OE_OUT,
  input wire logic                        OWNER_OUT
);
  // ========
  // Handshake lines
  logic stb_o;
  logic ack_o;
  logic give_o;
  logic stb_i;
  logic ack_i;
  logic req_i;

  // Short names keep the properties readable.
  assign stb_o  = LINK_OUT.ctl[iblp_pkg::CTL_STB];
  assign ack_o  = LINK_OUT.ctl[iblp_pkg::CTL_ACK];
  assign give_o = LINK_OUT.ctl[iblp_pkg::CTL_TOK_GIVE];
  assign stb_i  = LINK_IN.ctl[iblp_pkg::CTL_STB];
  assign ack_i  = LINK_IN.ctl[iblp_pkg::CTL_ACK];
  assign req_i  = LINK_IN.ctl[iblp_pkg::CTL_TOK_REQ];

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // The owner yields only after the other side asked.
  sequence s_handover;
    give_o && !OWNER_OUT && $past(req_i);
  endsequence
  sequence s_taken;
    stb_o && ack_i;
  endsequence

  property p_stb_hold;
    stb_o && !ack_i |=> stb_o && $stable(LINK_OUT.data);
  endproperty
  property p_stb_fall;
    s_taken |=> !stb_o;
  endproperty
  property p_no_early;
    !stb_o && ack_i |=> !stb_o;
  endproperty
  property p_ack_hold;
    ack_o && stb_i |=> ack_o;
  endproperty
  property p_ack_fall;
    ack_o && !stb_i |=> !ack_o;
  endproperty
  property p_rd_rise;
    $rose(RD_VALID_OUT) |-> ack_o && !OWNER_OUT;
  endproperty
  property p_rd_hold;
    RD_VALID_OUT && !RD_READY_IN |=> RD_VALID_OUT && $stable(RD_DATA_OUT);
  endproperty
  property p_wr_free;
    $rose(WR_READY_OUT) |-> ##[0:2] stb_o;
  endproperty
  // The giver releases acknowledge during its one-clock hand-over pulse.
  property p_oe;
    LINK_OE_OUT.data == {8{OWNER_OUT}} &&
    LINK_OE_OUT.ctl[iblp_pkg::CTL_STB] == OWNER_OUT &&
    LINK_OE_OUT.ctl[iblp_pkg::CTL_ACK] == (!OWNER_OUT && !give_o);
  endproperty
  property p_give;
    $rose(give_o) |-> s_handover ##1 !give_o;
  endproperty

  a_stb_hold: assert property (p_stb_hold)
    else $error("strobe or data moved before acknowledge");
  a_stb_fall: assert property (p_stb_fall)
    else $error("strobe held after acknowledge");
  a_no_early: assert property (p_no_early)
    else $error("next byte started while acknowledge high");
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge dropped while strobe high");
  a_ack_fall: assert property (p_ack_fall)
    else $error("acknowledge held after strobe fell");
  a_rd_rise: assert property (p_rd_rise)
    else $error("input word appeared without a byte taken");
  a_rd_hold: assert property (p_rd_hold)
    else $error("head word changed while not read");
  a_wr_free: assert property (p_wr_free)
    else $error("output buffer freed without a word leaving");
  a_oe: assert property (p_oe)
    else $error("line enables disagree with ownership");
  a_give: assert property (p_give)
    else $error("bad hand-over pulse");
endmodule

bind iblp_port iblp_port_asserts u_chk
(
  .CLK_SYS_IN   (CLK_SYS_IN),
  .RST_B_IN     (RST_B_IN),
  .RD_READY_IN  (RD_READY_IN),
  .RD_VALID_OUT (RD_VALID_OUT),
  .RD_DATA_OUT  (RD_DATA_OUT),
  .WR_READY_OUT (WR_READY_OUT),
  .LINK_IN      (LINK_IN),
  .LINK_OUT     (LINK_OUT),
  .LINK_OE_OUT  (LINK_OE_OUT),
  .OWNER_OUT    (OWNER_OUT)
);

`default_nettype wire

// *** iblp_peer.sv ***
// Behavioural model of the far port on the byte link.
`timescale 1ns/1ps
`default_nettype none

module iblp_peer
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 hold_in,
  input  wire iblp_pkg::iblp_link_t link_in,
  output iblp_pkg::iblp_link_t      link_out,
  output iblp_pkg::iblp_link_t      link_oe_out
);
  // ========
  // Model state
  logic [31:0] tx_q[$];
  logic [31:0] rx_q[$];
  logic        own_reg;
  logic        busy_reg;
  logic        sent_reg;
  logic [1:0]  idx_reg;
  logic [31:0] sh_reg;
  logic [31:0] acc_reg;

  // enables follow ownership; like the port, the giver releases
  // request and acknowledge during its hand-over pulse ({ctl, data}).
  assign link_oe_out = own_reg         ? 12'h6FF :
                       link_out.ctl[1] ? 12'h200 : 12'h900;

  // Both roles; hold_in withholds acknowledge to model a slow reader.
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      link_out <= '0;
      own_reg  <= 1'b0;
      busy_reg <= 1'b0;
      sent_reg <= 1'b0;
      idx_reg  <= 2'h0;
    end
    else if (!own_reg)
    begin
      // The hand-over pulse lasts one clock; our own must not count.
      link_out.ctl[1] <= 1'b0;
      link_out.ctl[0] <= (tx_q.size() != 0) && !link_in.ctl[1];
      if (link_in.ctl[1] && !link_out.ctl[1])
      begin
        own_reg  <= 1'b1;
        sent_reg <= 1'b0;
      end
      else if (link_in.ctl[2] && !link_out.ctl[3] && !hold_in)
      begin
        link_out.ctl[3] <= 1'b1;
        idx_reg <= idx_reg + 2'h1;
        acc_reg[{idx_reg, 3'h0} +: 8] <= link_in.data;
        if (idx_reg == 2'h3)
          rx_q.push_back({link_in.data, acc_reg[23:0]});
      end
      else if (!link_in.ctl[2])
        link_out.ctl[3] <= 1'b0;
    end
    else
    begin
      link_out.ctl[1] <= 1'b0;
      if (busy_reg && link_out.ctl[2] && link_in.ctl[3])
      begin
        link_out.ctl[2] <= 1'b0;
        idx_reg <= idx_reg + 2'h1;
      end
      else if (busy_reg && !link_out.ctl[2] && !link_in.ctl[3])
      begin
        busy_reg <= (idx_reg != 2'h0);
        sent_reg <= (idx_reg == 2'h0);
        link_out.ctl[2] <= (idx_reg != 2'h0);
        link_out.data <= sh_reg[{idx_reg, 3'h0} +: 8];
      end
      else if (!busy_reg && link_in.ctl[0] && (sent_reg || tx_q.size() == 0))
      begin
        link_out.ctl[1] <= 1'b1;
        own_reg <= 1'b0;
      end
      else if (!busy_reg && tx_q.size() != 0)
      begin
        busy_reg <= 1'b1;
        link_out.ctl[2] <= 1'b1;
        link_out.data <= tx_q[0][7:0];
        sh_reg <= tx_q.pop_front();
      end
    end
  end
endmodule

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: the link port against a model of the far port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module testbench;
  // ========
  // Signals and instances
  logic                 clk;
  logic                 rst_b;
  logic                 wr_v;
  logic [31:0]          wr_d;
  logic                 rd_r;
  logic                 hold;
  logic                 wr_rdy;
  logic                 rd_v;
  logic                 own;
  logic [31:0]          rd_d;
  int                   n_fail;
  int                   n_compared;
  iblp_pkg::iblp_link_t u_out;
  iblp_pkg::iblp_link_t u_oe;
  iblp_pkg::iblp_link_t p_out;
  iblp_pkg::iblp_link_t p_oe;
  iblp_pkg::iblp_link_t wire_w;

  // Undriven lines fall to zero, as the pull-downs do.
  assign wire_w = (u_out & u_oe) | (p_out & p_oe);

  always #2.5 clk = ~clk;

  iblp_port #(.OWNER_AT_RESET(1'b1)) uut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
    .WR_VALID_IN(wr_v), .WR_DATA_IN(wr_d), .WR_READY_OUT(wr_rdy),
    .RD_READY_IN(rd_r), .RD_VALID_OUT(rd_v), .RD_DATA_OUT(rd_d),
    .LINK_IN(wire_w), .LINK_OUT(u_out), .LINK_OE_OUT(u_oe), .OWNER_OUT(own));
  iblp_peer peer (.clk_in(clk), .rst_b_in(rst_b), .hold_in(hold),
    .link_in(wire_w), .link_out(p_out), .link_oe_out(p_oe));

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Offer a word; ok is low if refused for lim cycles.
  task automatic put(input logic [31:0] w, input int lim, output bit ok);
    int i;
    wr_v = 1'b1;
    wr_d = w;
    for (i = 0; wr_rdy !== 1'b1 && i < lim; i++)
      step();
    ok = (i < lim);
    if (ok)
      step();
  endtask

  task automatic get(input logic [31:0] e);
    for (int i = 0; rd_v !== 1'b1 && i < 400; i++)
      step();
    `CHK(rd_v, 1'b1)
    `CHK(rd_d, e)
    step();
  endtask

  task automatic chk_rx(input int n, input logic [31:0] base);
    for (int i = 0; peer.rx_q.size() < n && i < 3000; i++)
      step();
    `CHK(peer.rx_q.size(), n)
    for (int i = 0; i < n && i < peer.rx_q.size(); i++)
      `CHK(peer.rx_q[i], base + i)
  endtask

  task automatic t_reset();
    `CHK(wr_rdy, 1'b1)
    `CHK(rd_v, 1'b0)
    `CHK(own, 1'b1)
  endtask

  task automatic t_send(input int n, input logic [31:0] base);
    bit ok;
    peer.rx_q.delete();
    for (int i = 0; i < n; i++)
    begin
      put(base + i, 400, ok);
      `CHK(ok, 1'b1)
    end
    wr_v = 1'b0;
    chk_rx(n, base);
  endtask

  // Reader stalls, so one word waits on the link and eight queue.
  task automatic t_fill();
    bit ok;
    int k;
    time t0;
    hold = 1'b1;
    peer.rx_q.delete();
    ok = 1'b1;
    for (k = 0; ok && k < 12; k += ok)
      put(32'hA0B0_C0D0 + k, 8, ok);
    wr_v = 1'b0;
    `CHK(k, iblp_pkg::FIFO_DEPTH + 1)
    `CHK(u_out.ctl[iblp_pkg::CTL_STB], 1'b1)
    `CHK(u_out.data, 8'hD0)
    hold = 1'b0;
    t0 = $time;
    chk_rx(k, 32'hA0B0_C0D0);
    `CHK(($time - t0) <= 9 * 4 * iblp_pkg::CLK_PER_BYTE_MAX * 5, 1'b1)
  endtask

  task automatic t_recv();
    for (int i = 0; i < 9; i++)
      peer.tx_q.push_back(32'h5566_7788 + i);
    for (int i = 0; peer.tx_q.size() != 0 && i < 3000; i++)
      step();
    step(40);
    `CHK(peer.tx_q.size(), 0)
    `CHK(own, 1'b0)
    `CHK(u_out.ctl[iblp_pkg::CTL_ACK], 1'b0)
    `CHK(wire_w.ctl[iblp_pkg::CTL_STB], 1'b1)
    rd_r = 1'b1;
    for (int i = 0; i < 9; i++)
      get(32'h5566_7788 + i);
    rd_r = 1'b0;
  endtask

  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence; the second send needs the lines handed back.
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    wr_v = 1'b0;
    wr_d = '0;
    rd_r = 1'b0;
    hold = 1'b0;
    n_fail = 0;
    n_compared = 0;
    step(5);
    t_reset();
    rst_b = 1'b1;
    t_send(3, 32'h1122_3344);
    t_fill();
    t_recv();
    t_send(2, 32'h0F1E_2D3C);
    finish_test();
  end

  // Cut a hang short; a good run needs a small part of this.
  initial
  begin
    #200_000;
    n_fail++;
    finish_test();
  end
endmodule

`default_nettype wire
